// ==== design/sse_map.svh ====
// Constant map for the monitoring status encoder: field positions, codes and limits.
`ifndef SSE_MAP_SVH
`define SSE_MAP_SVH

// Attribute flag word field positions.
`define SSE_FLAG_PREFAIL_BIT 0
`define SSE_FLAG_ONLINE_BIT  1

// Normalized value end points.
`define SSE_NORM_MIN      8'h01
`define SSE_NORM_MAX      8'h64
`define SSE_NORM_PERF_MAX 8'hfd
`define SSE_NORM_WIN      8'hff

// Background collection status byte.
`define SSE_COLL_AUTO_BIT 7
`define SSE_COLL_NEVER    7'h00
`define SSE_COLL_DONE     7'h02
`define SSE_COLL_SUSP     7'h04
`define SSE_COLL_ABORT    7'h05
`define SSE_COLL_FATAL    7'h06
`define SSE_SEG_PTR       8'h01

// Collection capability bit positions.
`define SSE_CAP_IMM_BIT   0
`define SSE_CAP_AUTO_BIT  1
`define SSE_CAP_ABORT_BIT 2
`define SSE_CAP_SCAN_BIT  3
`define SSE_CAP_ST_BIT    4
`define SSE_CAP_SEL_BIT   6

// Monitoring capability word and its bits.
`define SSE_SMART_CAP      16'h0003
`define SSE_SMART_SAVE_BIT 0
`define SSE_SMART_AUTO_BIT 1

// Self-test status byte codes and limits.
`define SSE_ST_OK        4'h0
`define SSE_ST_HOST_ABRT 4'h1
`define SSE_ST_RESET     4'h2
`define SSE_ST_FATAL     4'h3
`define SSE_ST_FAIL_BASE 4'h4
`define SSE_ST_RUNNING   4'hf
`define SSE_ST_PCT_MAX   4'h9

// Timing: one second at the 4 ns clock.
`define SSE_SEC_NS 1000000000
`define SSE_CLK_NS 4

`endif

// ==== design/sse_pkg.sv ====
// Types shared by the monitoring status encoder.
package sse_pkg;

  typedef enum logic [1:0] {
    SSE_COLL_IDLE = 2'b00,
    SSE_COLL_RUN  = 2'b01,
    SSE_COLL_HOLD = 2'b10
  } sse_coll_state_t;

  typedef enum logic [1:0] {
    SSE_PS_IDLE = 2'b00,
    SSE_PS_SAVE = 2'b01,
    SSE_PS_WAIT = 2'b10
  } sse_pwr_state_t;

  typedef enum logic [1:0] {
    SSE_ELEM_UNKNOWN = 2'b00,
    SSE_ELEM_ELEC    = 2'b01,
    SSE_ELEM_SERVO   = 2'b10,
    SSE_ELEM_READ    = 2'b11
  } sse_elem_t;

endpackage

// ==== design/sse_norm.sv ====
// Raw error samples to normalized attribute value conversion.
`timescale 1ns/100ps
`include "sse_map.svh"

module sse_norm
  import sse_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sample_i,
  input  wire logic       err_i,
  input  wire logic       perf_i,
  output logic      [7:0] value_o
);

  logic [7:0] ops_reg;
  logic [7:0] err_reg;
  logic [7:0] value_reg;
  logic [7:0] target;
  logic [7:0] ceil_val;

  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    sat_sub = (a > b) ? 8'(a - b) : 8'h00;
  endfunction

  assign ceil_val = perf_i ? `SSE_NORM_PERF_MAX : `SSE_NORM_MAX;
  always_comb begin
    target = sat_sub(ceil_val, err_reg);
    if (target < `SSE_NORM_MIN) begin
      target = `SSE_NORM_MIN;
    end
  end

  // Errors are only judged over a full window of samples, and the value moves
  // one step per window unless a lowered ceiling clamps it at once, so an early burst cannot drag it to the threshold.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ops_reg <= 8'h00;
      err_reg <= 8'h00;
    end else if (sample_i) begin
      if (ops_reg == `SSE_NORM_WIN) begin
        ops_reg <= 8'h00;
        err_reg <= 8'h00;
      end else begin
        ops_reg <= 8'(ops_reg + 8'h01);
        if (err_i && err_reg != 8'hff) begin
          err_reg <= 8'(err_reg + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      value_reg <= `SSE_NORM_MAX;
    end else if (value_reg > ceil_val) begin
      value_reg <= ceil_val;
    end else if (sample_i && ops_reg == `SSE_NORM_WIN) begin
      if (target > value_reg) begin
        value_reg <= 8'(value_reg + 8'h01);
      end else if (target < value_reg) begin
        value_reg <= 8'(value_reg - 8'h01);
      end
    end
  end

  assign value_o = value_reg;

endmodule // sse_norm

// ==== design/sse_top.sv ====
// Monitoring status encoder: attribute flags, collection, self-test and capability fields.
`timescale 1ns/100ps
`include "sse_map.svh"

// Overview of operation
// - flag bit 0 clear and value at or below threshold signals advisory.
// - flag bit 0 set and value at or below threshold signals pre-failure.
// - flag bit 1 set means value also updates on-line, else only in background.
// - normalized values run from 1 up to 100.
// - performance and error-rate attributes may rise up to 253.
// - a short early error burst cannot push the value past threshold.
// - collection status bit 7 mirrors automatic collection enable.
// - code 0 before any collection, code 2 after clean completion.
// - code 4 suspended, 5 aborted by command, 6 fatal error.
// - self-test remaining work in tenths in bits 0 to 3, at most 9.
// - self-test status in bits 4 to 7, code 0 passed or never run.
// - code 1 host abort, 2 reset interruption, 3 fatal or unknown error.
// - failures report 4 unknown, 5 electrical, 6 servo, 7 read element.
// - code 15 while a self-test is running.
// - report whole seconds needed to finish background collection.
// - segment pointer always reads one.
// - capability bits 0 and 1 show immediate and automatic collection support.
// - capability bit 2 set aborts on new command, clear suspends then resumes.
// - bits 3, 4, 6 show scan, self-test, selective test; 5 and 7 zero.
// - monitoring capability word reads 03h.
// - attributes are saved before entering standby or sleep.
// - capability bit 1 declares autosave enable command support.
module sse_top
  import sse_pkg::*;
#(
  parameter int SEC_CYCLES = `SSE_SEC_NS / `SSE_CLK_NS
)
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        raw_valid_i,
  input  wire logic        raw_err_i,
  input  wire logic        perf_attr_i,
  input  wire logic        prefail_cfg_i,
  input  wire logic        online_cfg_i,
  input  wire logic [7:0]  threshold_i,
  output logic      [7:0]  attr_value_o,
  output logic      [15:0] attr_flags_o,
  output logic             advisory_o,
  output logic             prefail_o,
  input  wire logic        auto_coll_en_i,
  input  wire logic        coll_start_i,
  input  wire logic        coll_done_i,
  input  wire logic        coll_intr_i,
  input  wire logic        coll_resume_i,
  input  wire logic        coll_fatal_i,
  input  wire logic [15:0] coll_time_est_i,
  output logic      [7:0]  coll_status_o,
  output logic      [15:0] coll_time_o,
  output logic      [7:0]  seg_ptr_o,
  input  wire logic        cap_imm_i,
  input  wire logic        cap_auto_i,
  input  wire logic        cap_abort_i,
  input  wire logic        cap_scan_i,
  input  wire logic        cap_st_i,
  input  wire logic        cap_sel_i,
  output logic      [7:0]  coll_cap_o,
  output logic      [15:0] smart_cap_o,
  input  wire logic        st_start_i,
  input  wire logic        st_remain_vld_i,
  input  wire logic [3:0]  st_remain_i,
  input  wire logic        st_done_i,
  input  wire logic        st_fail_i,
  input  wire logic [1:0]  st_elem_i,
  input  wire logic        st_host_abort_i,
  input  wire logic        st_link_reset_i,
  input  wire logic        st_fatal_i,
  output logic      [7:0]  st_status_o,
  input  wire logic        pwr_save_req_i,
  input  wire logic        save_done_i,
  output logic             attr_save_o,
  output logic             pwr_save_go_o
);

  // Attribute path.

  logic            coll_running;
  logic            norm_sample;
  logic [7:0]      norm_value;
  logic [15:0]     flags_reg;
  logic            advisory_reg;
  logic            prefail_reg;
  logic            trip;

  function automatic logic [3:0] clamp_pct(input logic [3:0] pct);
    clamp_pct = (pct > `SSE_ST_PCT_MAX) ? `SSE_ST_PCT_MAX : pct;
  endfunction

  // Off-line-only attributes move only while background collection runs.
  assign norm_sample = raw_valid_i && (online_cfg_i || coll_running);

  sse_norm u_norm (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (norm_sample),
    .err_i     (raw_err_i),
    .perf_i    (perf_attr_i),
    .value_o   (norm_value)
  );

  assign trip = (norm_value <= threshold_i);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_reg <= 16'h0000;
    end else begin
      flags_reg                       <= 16'h0000;
      flags_reg[`SSE_FLAG_PREFAIL_BIT] <= prefail_cfg_i;
      flags_reg[`SSE_FLAG_ONLINE_BIT]  <= online_cfg_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      advisory_reg <= 1'b0;
      prefail_reg  <= 1'b0;
    end else begin
      advisory_reg <= trip && !prefail_cfg_i;
      prefail_reg  <= trip && prefail_cfg_i;
    end
  end

  assign attr_value_o = norm_value;
  assign attr_flags_o = flags_reg;
  assign advisory_o   = advisory_reg;
  assign prefail_o    = prefail_reg;

  // Background collection.

  sse_coll_state_t coll_state_reg;
  sse_coll_state_t coll_state_next;
  logic [6:0]      coll_code_reg;
  logic [7:0]      coll_status_reg;
  logic [31:0]     tick_cnt_reg;
  logic [15:0]     run_secs_reg;
  logic [15:0]     meas_secs_reg;
  logic            meas_vld_reg;
  logic [15:0]     coll_time_reg;
  logic            sec_tick;

  assign coll_running = (coll_state_reg == SSE_COLL_RUN);

  always_comb begin
    coll_state_next = coll_state_reg;
    case (coll_state_reg)
      SSE_COLL_IDLE: begin
        if (coll_start_i) begin
          coll_state_next = SSE_COLL_RUN;
        end
      end
      SSE_COLL_RUN: begin
        if (coll_fatal_i || coll_done_i) begin
          coll_state_next = SSE_COLL_IDLE;
        end else if (coll_intr_i) begin
          coll_state_next = cap_abort_i ? SSE_COLL_IDLE : SSE_COLL_HOLD;
        end
      end
      SSE_COLL_HOLD: begin
        if (coll_fatal_i) begin
          coll_state_next = SSE_COLL_IDLE;
        end else if (coll_resume_i) begin
          coll_state_next = SSE_COLL_RUN;
        end else if (coll_start_i) begin
          coll_state_next = SSE_COLL_RUN;
        end
      end
      default: begin
        coll_state_next = SSE_COLL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      coll_state_reg <= SSE_COLL_IDLE;
    end else begin
      coll_state_reg <= coll_state_next;
    end
  end

  // A start leaves the last code in place; only outcomes change it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      coll_code_reg <= `SSE_COLL_NEVER;
    end else if (coll_state_reg != SSE_COLL_IDLE) begin
      if (coll_fatal_i) begin
        coll_code_reg <= `SSE_COLL_FATAL;
      end else if (coll_running && coll_done_i) begin
        coll_code_reg <= `SSE_COLL_DONE;
      end else if (coll_running && coll_intr_i) begin
        coll_code_reg <= cap_abort_i ? `SSE_COLL_ABORT : `SSE_COLL_SUSP;
      end
    end
  end

  // The enable bit and the code leave one register so a read is never torn.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      coll_status_reg <= 8'h00;
    end else begin
      coll_status_reg <= {auto_coll_en_i, coll_code_reg};
    end
  end

  assign sec_tick = (tick_cnt_reg == 32'(SEC_CYCLES - 1));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (!coll_running || sec_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= 32'(tick_cnt_reg + 32'h0000_0001);
    end
  end

  // Run time is accumulated across suspensions; a fresh start clears it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      run_secs_reg <= 16'h0000;
    end else if (coll_state_reg == SSE_COLL_IDLE && coll_start_i) begin
      run_secs_reg <= 16'h0000;
    end else if (sec_tick && run_secs_reg != 16'hffff) begin
      run_secs_reg <= 16'(run_secs_reg + 16'h0001);
    end
  end

  // A partial second still costs the host a whole one, so round up.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meas_secs_reg <= 16'h0000;
      meas_vld_reg  <= 1'b0;
    end else if (coll_running && coll_done_i && !coll_fatal_i) begin
      meas_secs_reg <= (run_secs_reg == 16'hffff) ? run_secs_reg
                       : 16'(run_secs_reg + 16'h0001);
      meas_vld_reg  <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      coll_time_reg <= 16'h0000;
    end else if (meas_vld_reg && meas_secs_reg > coll_time_est_i) begin
      coll_time_reg <= meas_secs_reg;
    end else begin
      coll_time_reg <= coll_time_est_i;
    end
  end

  assign coll_status_o = coll_status_reg;
  assign coll_time_o   = coll_time_reg;
  assign seg_ptr_o     = `SSE_SEG_PTR;

  // Capability fields.

  logic [7:0] cap_reg;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cap_reg <= 8'h00;
    end else begin
      cap_reg                     <= 8'h00;
      cap_reg[`SSE_CAP_IMM_BIT]   <= cap_imm_i;
      cap_reg[`SSE_CAP_AUTO_BIT]  <= cap_auto_i;
      cap_reg[`SSE_CAP_ABORT_BIT] <= cap_abort_i;
      cap_reg[`SSE_CAP_SCAN_BIT]  <= cap_scan_i;
      cap_reg[`SSE_CAP_ST_BIT]    <= cap_st_i;
      cap_reg[`SSE_CAP_SEL_BIT]   <= cap_sel_i;
    end
  end

  assign coll_cap_o  = cap_reg;
  assign smart_cap_o = `SSE_SMART_CAP;

  // Self-test status byte.

  logic [7:0] st_status_reg;
  logic       st_running;

  assign st_running = (st_status_reg[7:4] == `SSE_ST_RUNNING);

  // Outcome events outrank progress updates; code and progress are always written
  // in the same edge, which is why they share one register.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_status_reg <= {`SSE_ST_OK, 4'h0};
    end else if (st_start_i && !st_running) begin
      st_status_reg <= {`SSE_ST_RUNNING, `SSE_ST_PCT_MAX};
    end else if (st_running) begin
      if (st_fatal_i) begin
        st_status_reg <= {`SSE_ST_FATAL, st_status_reg[3:0]};
      end else if (st_link_reset_i) begin
        st_status_reg <= {`SSE_ST_RESET, st_status_reg[3:0]};
      end else if (st_host_abort_i) begin
        st_status_reg <= {`SSE_ST_HOST_ABRT, st_status_reg[3:0]};
      end else if (st_done_i && st_fail_i) begin
        st_status_reg <= {4'(`SSE_ST_FAIL_BASE + {2'b00, st_elem_i}), 4'h0};
      end else if (st_done_i) begin
        st_status_reg <= {`SSE_ST_OK, 4'h0};
      end else if (st_remain_vld_i) begin
        st_status_reg <= {`SSE_ST_RUNNING, clamp_pct(st_remain_i)};
      end
    end
  end

  assign st_status_o = st_status_reg;

  // Save before power saving.

  sse_pwr_state_t pwr_state_reg;
  sse_pwr_state_t pwr_state_next;
  logic           save_cap;

  assign save_cap = 1'(`SSE_SMART_CAP >> `SSE_SMART_SAVE_BIT);

  always_comb begin
    pwr_state_next = pwr_state_reg;
    case (pwr_state_reg)
      SSE_PS_IDLE: begin
        if (pwr_save_req_i) begin
          pwr_state_next = save_cap ? SSE_PS_SAVE : SSE_PS_IDLE;
        end
      end
      SSE_PS_SAVE: begin
        pwr_state_next = SSE_PS_WAIT;
      end
      SSE_PS_WAIT: begin
        if (save_done_i) begin
          pwr_state_next = SSE_PS_IDLE;
        end
      end
      default: begin
        pwr_state_next = SSE_PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pwr_state_reg <= SSE_PS_IDLE;
    end else begin
      pwr_state_reg <= pwr_state_next;
    end
  end

  // Standby is only released once the store reports the save finished.
  assign attr_save_o   = (pwr_state_reg == SSE_PS_SAVE);
  assign pwr_save_go_o = (pwr_state_reg == SSE_PS_WAIT) && save_done_i;

endmodule // sse_top

// ==== sim/sse_top_assertions.sv ====
// Concurrent checks on the ports of the monitoring status encoder.
`timescale 1ns/100ps
module sse_top_assertions (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        prefail_cfg_i,
  input wire logic        online_cfg_i,
  input wire logic [7:0]  threshold_i,
  input wire logic [7:0]  attr_value_o,
  input wire logic [15:0] attr_flags_o,
  input wire logic        advisory_o,
  input wire logic        prefail_o,
  input wire logic        coll_start_i,
  input wire logic        coll_done_i,
  input wire logic        coll_intr_i,
  input wire logic        coll_fatal_i,
  input wire logic [7:0]  coll_status_o,
  input wire logic [7:0]  seg_ptr_o,
  input wire logic [15:0] smart_cap_o,
  input wire logic        st_start_i,
  input wire logic [7:0]  st_status_o
);
  // Registered outputs lag their inputs, so lagged checks wait two clean edges after reset.
  logic [1:0] rst_q;
  wire        settled = (rst_q == 2'b00);
  always_ff @(posedge clock_i) rst_q <= {rst_q[0], sys_rst_i};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_start;
    coll_start_i && !coll_done_i && !coll_intr_i && !coll_fatal_i;
  endsequence
  sequence s_quiet;
    !coll_start_i && !coll_done_i && !coll_intr_i && !coll_fatal_i;
  endsequence
  sequence s_lead;
    s_start ##1 s_quiet;
  endsequence
  a_const_fields: assert property (seg_ptr_o == 8'h01 && smart_cap_o == 16'h0003)
    else $error("constant field wrong");
  a_flag_word: assert property (settled |-> attr_flags_o == {14'h0, $past(online_cfg_i), $past(prefail_cfg_i)})
    else $error("flag word wrong");
  a_advisory_cond: assert property (settled && $stable(prefail_cfg_i) && prefail_cfg_i == $past(prefail_cfg_i, 2)
    && $stable(threshold_i) && $stable(attr_value_o) |-> advisory_o == (attr_value_o <= threshold_i && !prefail_cfg_i))
    else $error("advisory wrong");
  a_prefail_cond: assert property (settled && $stable(prefail_cfg_i) && prefail_cfg_i == $past(prefail_cfg_i, 2)
    && $stable(threshold_i) && $stable(attr_value_o) |-> prefail_o == (attr_value_o <= threshold_i && prefail_cfg_i))
    else $error("prefail wrong");
  a_value_range: assert property (attr_value_o >= 8'h01 && attr_value_o <= 8'hfd)
    else $error("value out of range");
  a_value_step: assert property (settled |-> attr_value_o == $past(attr_value_o)
    || attr_value_o == $past(attr_value_o) + 8'h01 || attr_value_o == $past(attr_value_o) - 8'h01)
    else $error("value jumped");
  a_st_start: assert property (st_start_i && st_status_o[7:4] != 4'hf |=> st_status_o == 8'hf9)
    else $error("self-test start wrong");
  a_coll_done: assert property (s_lead ##1 (coll_done_i && !coll_fatal_i) |-> ##2 coll_status_o[6:0] == 7'h02)
    else $error("collection done code wrong");
endmodule // sse_top_assertions

bind sse_top sse_top_assertions u_chk (
  .clock_i, .sys_rst_i, .prefail_cfg_i, .online_cfg_i, .threshold_i, .attr_value_o,
  .attr_flags_o, .advisory_o, .prefail_o, .coll_start_i, .coll_done_i, .coll_intr_i,
  .coll_fatal_i, .coll_status_o, .seg_ptr_o, .smart_cap_o, .st_start_i, .st_status_o
);

// ==== sim/sse_store_model.sv ====
// Attribute store model: answers a save request after a set number of cycles.
`timescale 1ns/100ps
module sse_store_model (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       save_i,
  input  wire logic [3:0] delay_i,
  output logic            save_done_o
);
  logic [3:0] left_reg;
  // The delay must be at least one, since a delay of zero never counts down to one and never signals completion.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      left_reg <= 4'h0;
      save_done_o <= 1'b0;
    end else begin
      save_done_o <= (left_reg == 4'h1);
      if (save_i) left_reg <= delay_i;
      else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
    end
  end
endmodule // sse_store_model

// ==== sim/smart_status_encoder_bench.sv ====
// Self-checking bench for the monitoring status encoder.
`timescale 1ns/100ps
module smart_status_encoder_bench;
  logic clock_i, sys_rst_i, raw_valid_i, raw_err_i, perf_attr_i, prefail_cfg_i, online_cfg_i;
  logic auto_coll_en_i, coll_start_i, coll_done_i, coll_intr_i, coll_resume_i, coll_fatal_i;
  logic cap_imm_i, cap_auto_i, cap_abort_i, cap_scan_i, cap_st_i, cap_sel_i, save_done_i;
  logic st_start_i, st_remain_vld_i, st_done_i, st_fail_i, st_host_abort_i, st_link_reset_i;
  logic st_fatal_i, pwr_save_req_i, advisory_o, prefail_o, attr_save_o, pwr_save_go_o;
  logic [1:0]  st_elem_i;
  logic [3:0]  st_remain_i, dly;
  logic [7:0]  threshold_i, attr_value_o, coll_status_o, seg_ptr_o, coll_cap_o, st_status_o, ev;
  logic [15:0] coll_time_est_i, attr_flags_o, coll_time_o, smart_cap_o;
  int          bad_count, checks_done, r;

  sse_top #(.SEC_CYCLES(10)) dut (
    .clock_i, .sys_rst_i, .raw_valid_i, .raw_err_i, .perf_attr_i, .prefail_cfg_i,
    .online_cfg_i, .threshold_i, .attr_value_o, .attr_flags_o, .advisory_o, .prefail_o,
    .auto_coll_en_i, .coll_start_i, .coll_done_i, .coll_intr_i, .coll_resume_i,
    .coll_fatal_i, .coll_time_est_i, .coll_status_o, .coll_time_o, .seg_ptr_o, .cap_imm_i,
    .cap_auto_i, .cap_abort_i, .cap_scan_i, .cap_st_i, .cap_sel_i, .coll_cap_o, .smart_cap_o,
    .st_start_i, .st_remain_vld_i, .st_remain_i, .st_done_i, .st_fail_i, .st_elem_i,
    .st_host_abort_i, .st_link_reset_i, .st_fatal_i, .st_status_o, .pwr_save_req_i,
    .save_done_i, .attr_save_o, .pwr_save_go_o
  );
  sse_store_model store (.clock_i, .sys_rst_i, .save_i(attr_save_o), .delay_i(dly),
    .save_done_o(save_done_i));

  always #2 clock_i = ~clock_i;

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] v, input int e, input logic p);
    int t;
    t = (p ? 253 : 100) - e;
    if (t < 1) t = 1;
    if (t < int'(v)) return v - 8'h01;
    if (t > int'(v)) return v + 8'h01;
    return v;
  endfunction
  // One full window of back-to-back samples; the closing sample never carries an error.
  task automatic win(input int errs);
    for (int i = 0; i < 256; i++) begin
      raw_valid_i = 1'b1;
      raw_err_i = (i < errs);
      tick(1);
    end
    raw_valid_i = 1'b0;
    raw_err_i = 1'b0;
    tick(2);
    if (online_cfg_i) ev = nxt(ev, errs, perf_attr_i);
    chk(attr_value_o, ev);
  endtask
  // Collection status lands two edges after its event, which the pulse already waits; one edge more is added here.
  task automatic cchk(input logic [6:0] code);
    tick(1);
    chk(coll_status_o, {auto_coll_en_i, code});
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #280000;
    bad_count++;
    wrap_up;
  end

  initial begin
    clock_i = 1'b0;
    sys_rst_i = 1'b1;
    {raw_valid_i, raw_err_i, perf_attr_i, prefail_cfg_i, online_cfg_i, auto_coll_en_i} = '0;
    {coll_start_i, coll_done_i, coll_intr_i, coll_resume_i, coll_fatal_i, pwr_save_req_i} = '0;
    {cap_imm_i, cap_auto_i, cap_abort_i, cap_scan_i, cap_st_i, cap_sel_i} = '0;
    {st_start_i, st_remain_vld_i, st_done_i, st_fail_i, st_host_abort_i, st_link_reset_i} = '0;
    {st_fatal_i, st_elem_i, st_remain_i, threshold_i} = '0;
    coll_time_est_i = 16'h0002;
    dly = 4'h1;
    bad_count = 0;
    checks_done = 0;
    ev = 8'h64;
    r = $urandom(32'h1a95);
    tick(20);
    sys_rst_i = 1'b0;
    tick(2);
    chk(attr_value_o, 8'h64);
    chk(seg_ptr_o, 8'h01);
    chk(smart_cap_o, 16'h0003);
    chk(coll_status_o, 8'h00);
    chk(st_status_o, 8'h00);
    chk(coll_time_o, 16'h0002);
    online_cfg_i = 1'b1;
    win(255);
    win(0);
    for (int k = 0; k < 4; k++) win($urandom % 256);
    chk(attr_flags_o, 16'h0002);
    threshold_i = ev;
    tick(3);
    chk(advisory_o, 1'b1);
    chk(prefail_o, 1'b0);
    prefail_cfg_i = 1'b1;
    tick(3);
    chk(prefail_o, 1'b1);
    chk(advisory_o, 1'b0);
    threshold_i = ev - 8'h01;
    tick(3);
    chk(prefail_o, 1'b0);
    online_cfg_i = 1'b0;
    win(255);
    online_cfg_i = 1'b1;
    perf_attr_i = 1'b1;
    while (ev != 8'hfd) win(0);
    win(0);
    chk(attr_value_o, 8'hfd);
    for (int k = 0; k < 4; k++) begin
      {cap_imm_i, cap_auto_i, cap_abort_i, cap_scan_i, cap_st_i, cap_sel_i} = 6'($urandom);
      tick(2);
      chk(coll_cap_o, {1'b0, cap_sel_i, 1'b0, cap_st_i, cap_scan_i, cap_abort_i, cap_auto_i, cap_imm_i});
    end
    auto_coll_en_i = 1'b1;
    pulse(coll_done_i);
    cchk(7'h00);
    pulse(coll_start_i);
    tick(45);
    pulse(coll_done_i);
    cchk(7'h02);
    chk(coll_time_o, 16'h0005);
    coll_time_est_i = 16'h0009;
    tick(2);
    chk(coll_time_o, 16'h0009);
    cap_abort_i = 1'b1;
    pulse(coll_start_i);
    pulse(coll_intr_i);
    cchk(7'h05);
    pulse(coll_start_i);
    pulse(coll_done_i);
    cchk(7'h02);
    cap_abort_i = 1'b0;
    pulse(coll_start_i);
    pulse(coll_intr_i);
    cchk(7'h04);
    pulse(coll_resume_i);
    pulse(coll_done_i);
    cchk(7'h02);
    pulse(coll_start_i);
    pulse(coll_intr_i);
    pulse(coll_fatal_i);
    cchk(7'h06);
    auto_coll_en_i = 1'b0;
    tick(2);
    chk(coll_status_o, 8'h06);
    for (int e = 0; e < 4; e++) begin
      pulse(st_start_i);
      chk(st_status_o, 8'hf9);
      r = (e == 0) ? 10 : $urandom % 16;
      st_remain_i = 4'(r);
      pulse(st_remain_vld_i);
      chk(st_status_o, {4'hf, (r > 9) ? 4'h9 : 4'(r)});
      st_elem_i = 2'(e);
      st_fail_i = 1'b1;
      pulse(st_done_i);
      st_fail_i = 1'b0;
      chk(st_status_o, {2'b01, 2'(e), 4'h0});
    end
    pulse(st_start_i);
    st_remain_i = 4'h3;
    pulse(st_remain_vld_i);
    pulse(st_start_i);
    chk(st_status_o, 8'hf3);
    pulse(st_host_abort_i);
    chk(st_status_o, 8'h13);
    pulse(st_start_i);
    pulse(st_link_reset_i);
    chk(st_status_o, 8'h29);
    pulse(st_start_i);
    pulse(st_fatal_i);
    chk(st_status_o, 8'h39);
    pulse(st_start_i);
    pulse(st_done_i);
    chk(st_status_o, 8'h00);
    for (int d = 1; d < 9; d += 6) begin
      dly = 4'(d);
      pwr_save_req_i = 1'b1;
      tick(1);
      pwr_save_req_i = 1'b0;
      chk(attr_save_o, 1'b1);
      chk(pwr_save_go_o, 1'b0);
      tick(1);
      chk(attr_save_o, 1'b0);
      for (int i = 0; i < 20 && pwr_save_go_o !== 1'b1; i++) tick(1);
      chk(pwr_save_go_o, 1'b1);
      tick(2);
    end
    wrap_up;
  end
endmodule // smart_status_encoder_bench
